// *** chan_engine_model.sv ***
/*
 * Stand-in for the channel engine that raises one-cycle event pulses.
 * Assumes the bench calls fire from its main sequence on the shared system clock.
 */
`timescale 1ns/1ns
module chan_engine_model (
    input  wire logic       clk_in,
    output logic      [7:0] buffer_done_out,
    output logic      [7:0] chain_done_out,
    output logic      [7:0] bus_error_out
);
    initial {bus_error_out, chain_done_out, buffer_done_out} = 24'h00_0000;

    task automatic fire(input logic [23:0] evt);
        @(posedge clk_in);
        {bus_error_out, chain_done_out, buffer_done_out} <= evt;
        @(posedge clk_in);
        {bus_error_out, chain_done_out, buffer_done_out} <= 24'h00_0000;
    endtask
endmodule // chan_engine_model

// *** dma_regs_pkg.sv ***
/*
 * Shared constants for the DMA global control, software request and interrupt register group.
 * Assumes a 32-bit register port with byte offsets and eight channels.
 */
package dma_regs_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_ENABLE      = 12'h004;
    localparam logic [11:0] OFS_SGL_REQ     = 12'h008;
    localparam logic [11:0] OFS_CHK_REQ     = 12'h00C;
    localparam logic [11:0] OFS_FINAL       = 12'h010;
    localparam logic [11:0] OFS_MASK_SET    = 12'h018;
    localparam logic [11:0] OFS_MASK_CLR    = 12'h01C;
    localparam logic [11:0] OFS_MASK_VIEW   = 12'h020;
    localparam logic [11:0] OFS_STATUS      = 12'h024;
    localparam int          ENABLE_BIT      = 0;
    localparam int          BUF_LSB         = 0;
    localparam int          CHAIN_LSB       = 8;
    localparam int          ERR_LSB         = 16;
    localparam int          EVT_W           = 24;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
endpackage : dma_regs_pkg

// *** dma_sw_request_irq_regs.sv ***
/*
 * Global enable, software request, final marker and interrupt mask/status registers of an
 * eight-channel DMA controller. Assumes the channel engine drives one-cycle event pulses on
 * the system clock and consumes the one-cycle request pulses this block produces.
 */
// The strobed register port and the placing of the registers were decided locally.
// What this block does
// - Enable register bit zero drives ctrl_enable_out and gates the software request pulses; status flags and the interrupt work regardless.
// - Writing one at bit 2x requests a source single transfer on channel x.
// - Writing one at bit 2x+1 requests a destination single transfer.
// - Writing one at bit 2x of chunk register requests source chunk transfer.
// - Writing one at bit 2x+1 of chunk register requests destination chunk transfer.
// - Destination final marker set beforehand flags the destination request as last.
// - Source final marker set beforehand flags the source request as last.
// - Ones written to mask set register enable the matching interrupt mask bits.
// - Ones written to mask clear register disable the matching mask bits.
// - Mask view bits 7:0 show enabled buffer-complete interrupts.
// - Mask view bits 15:8 show enabled chained-buffer interrupts.
// - Mask view bits 23:16 show enabled error interrupts.
// - Buffer-complete status sets when a channel buffer terminates.
// - Chained status sets when chain terminates; descriptor fetching stops then.
// - Error status sets when a channel sees a bus error response.
`timescale 1ns/1ns
module dma_sw_request_irq_regs (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic [7:0]  buffer_done_in,
    input  wire logic [7:0]  chain_done_in,
    input  wire logic [7:0]  bus_error_in,
    output logic             ctrl_enable_out,
    output logic      [7:0]  src_single_req_out,
    output logic      [7:0]  dst_single_req_out,
    output logic      [7:0]  src_chunk_req_out,
    output logic      [7:0]  dst_chunk_req_out,
    output logic      [7:0]  src_final_out,
    output logic      [7:0]  dst_final_out,
    output logic      [7:0]  descriptor_fetch_stop_out,
    output logic             irq_out
);

    logic        enable_ff;
    logic [15:0] final_ff;
    logic [15:0] sgl_ff;
    logic [15:0] chk_ff;
    logic [15:0] last_sgl_ff;
    logic [15:0] last_chk_ff;
    logic [23:0] mask_ff;
    logic [23:0] status_ff;
    logic [31:0] rdata_ff;
    logic [23:0] evt_set;
    logic [31:0] nxt_rdata;

    // Even bits of a request word belong to the source side, odd bits to the destination.
    function automatic logic [7:0] pick_lanes(input logic [15:0] w, input logic odd);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < dma_regs_pkg::NUM_CH; i++) begin
            r[i] = w[2*i + int'(odd)];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable_ff <= 1'b0;
        end else if (wr_in && hit(addr_in, dma_regs_pkg::OFS_ENABLE)) begin
            enable_ff <= wdata_in[dma_regs_pkg::ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            final_ff <= dma_regs_pkg::RST_ZERO[15:0];
        end else if (wr_in && hit(addr_in, dma_regs_pkg::OFS_FINAL)) begin
            final_ff <= wdata_in[15:0];
        end else begin
            // A marker is consumed by the request it qualifies, so a stale one cannot leak.
            final_ff <= final_ff & ~(sgl_ff | chk_ff);
        end
    end

    // gate by enable
    // Requests are one-cycle pulses; a write while disabled is dropped rather than queued.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sgl_ff <= dma_regs_pkg::RST_ZERO[15:0];
            chk_ff <= dma_regs_pkg::RST_ZERO[15:0];
        end else begin
            sgl_ff <= (wr_in && enable_ff && hit(addr_in, dma_regs_pkg::OFS_SGL_REQ)) ?
                      wdata_in[15:0] : 16'h0000;
            chk_ff <= (wr_in && enable_ff && hit(addr_in, dma_regs_pkg::OFS_CHK_REQ)) ?
                      wdata_in[15:0] : 16'h0000;
        end
    end

    // Last-issued request words read back so software can see what was sent.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_sgl_ff <= dma_regs_pkg::RST_ZERO[15:0];
            last_chk_ff <= dma_regs_pkg::RST_ZERO[15:0];
        end else begin
            if (|sgl_ff) begin
                last_sgl_ff <= sgl_ff;
            end
            if (|chk_ff) begin
                last_chk_ff <= chk_ff;
            end
        end
    end

    assign ctrl_enable_out    = enable_ff;
    assign dst_single_req_out = pick_lanes(sgl_ff, 1'b1);
    assign src_single_req_out = pick_lanes(sgl_ff, 1'b0);
    assign dst_chunk_req_out  = pick_lanes(chk_ff, 1'b1);
    assign src_chunk_req_out  = pick_lanes(chk_ff, 1'b0);
    assign dst_final_out      = pick_lanes(final_ff & (sgl_ff | chk_ff), 1'b1);
    assign src_final_out      = pick_lanes(final_ff & (sgl_ff | chk_ff), 1'b0);

    // set ones, clear ones, zeros keep
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_ff <= dma_regs_pkg::RST_ZERO[23:0];
        end else if (wr_in && hit(addr_in, dma_regs_pkg::OFS_MASK_SET)) begin
            mask_ff <= mask_ff | wdata_in[23:0];
        end else if (wr_in && hit(addr_in, dma_regs_pkg::OFS_MASK_CLR)) begin
            mask_ff <= mask_ff & ~wdata_in[23:0];
        end
    end

    assign evt_set = {bus_error_in, chain_done_in, buffer_done_in};

    // Write one to clear; a new event in the same cycle wins so none is lost.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_ff <= dma_regs_pkg::RST_ZERO[23:0];
        end else if (wr_in && hit(addr_in, dma_regs_pkg::OFS_STATUS)) begin
            status_ff <= (status_ff & ~wdata_in[23:0]) | evt_set;
        end else begin
            status_ff <= status_ff | evt_set;
        end
    end

    assign descriptor_fetch_stop_out = status_ff[dma_regs_pkg::CHAIN_LSB +: 8];

    assign irq_out = |(status_ff & mask_ff);

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (addr_in)
            dma_regs_pkg::OFS_ENABLE:    nxt_rdata[0] = enable_ff;
            dma_regs_pkg::OFS_SGL_REQ:   nxt_rdata[15:0] = last_sgl_ff;
            dma_regs_pkg::OFS_CHK_REQ:   nxt_rdata[15:0] = last_chk_ff;
            dma_regs_pkg::OFS_FINAL:     nxt_rdata[15:0] = final_ff;
            dma_regs_pkg::OFS_MASK_VIEW: nxt_rdata[23:0] = mask_ff;
            dma_regs_pkg::OFS_STATUS:    nxt_rdata[23:0] = status_ff;
            default:                     nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_ff <= dma_regs_pkg::RST_ZERO;
        end else begin
            rdata_ff <= rd_in ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign rdata_out = rdata_ff;

    enable_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_ENABLE |=> ctrl_enable_out == $past(wdata_in[0]))
        else $error("enable bit not taken");

    single_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_SGL_REQ && wdata_in[0]
        |=> src_single_req_out[0]
        // A write right behind the first may legally keep the pulse up a second cycle.
        ##1 (!src_single_req_out[0] || $past(wr_in)))
        else $error("source single request not pulsed");

    dst_single_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_SGL_REQ && wdata_in[15]
        |=> dst_single_req_out[7])
        else $error("destination single request missing");

    src_chunk_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_CHK_REQ && wdata_in[2]
        |=> src_chunk_req_out[1])
        else $error("source chunk request missing");

    dst_chunk_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_CHK_REQ && wdata_in[1]
        |=> dst_chunk_req_out[0])
        else $error("destination chunk request missing");

    final_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (dst_single_req_out[0] || dst_chunk_req_out[0]) && final_ff[1] |-> dst_final_out[0])
        else $error("destination last flag not passed");

    mask_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_MASK_SET |=> (mask_ff & $past(wdata_in[23:0]))
        == $past(wdata_in[23:0]))
        else $error("mask set failed");

    mask_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_MASK_CLR |=> (mask_ff & $past(wdata_in[23:0]))
        == 24'h00_0000)
        else $error("mask clear failed");

    mask_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == dma_regs_pkg::OFS_MASK_VIEW |=> rdata_out == {8'h00, $past(mask_ff)})
        else $error("mask view wrong");

    event_sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        buffer_done_in[0] |=> status_ff[0])
        else $error("buffer event lost");

    irq_level_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        irq_out == |(status_ff & mask_ff))
        else $error("interrupt level wrong");

    disabled_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !enable_ff |=> !(|src_single_req_out) && !(|dst_single_req_out)
            && !(|src_chunk_req_out) && !(|dst_chunk_req_out))
        else $error("request while disabled");

    // Bits above the enable bit are unused, so only bit zero may switch the controller.
    enable_width_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_ENABLE && !wdata_in[dma_regs_pkg::ENABLE_BIT]
        |=> !ctrl_enable_out)
        else $error("enable taken from an unused bit");

    enable_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !(wr_in && addr_in == dma_regs_pkg::OFS_ENABLE) |=> $stable(ctrl_enable_out))
        else $error("enable changed without a write");

    final_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_FINAL |=> final_ff == $past(wdata_in[15:0]))
        else $error("final markers not stored");

    // A marker qualifies one request only; a later request must not inherit it.
    dst_consume_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        dst_final_out[0] && !(wr_in && addr_in == dma_regs_pkg::OFS_FINAL)
        |=> !final_ff[1])
        else $error("destination marker not consumed");

    src_consume_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        src_final_out[0] && !(wr_in && addr_in == dma_regs_pkg::OFS_FINAL)
        |=> !final_ff[0])
        else $error("source marker not consumed");

    src_no_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !src_single_req_out[0] && !src_chunk_req_out[0] |-> !src_final_out[0])
        else $error("source last flag without request");

    dst_no_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !dst_single_req_out[0] && !dst_chunk_req_out[0] |-> !dst_final_out[0])
        else $error("destination last flag without request");

    src_lanes_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_SGL_REQ
        |=> src_single_req_out == $past({wdata_in[14], wdata_in[12], wdata_in[10],
            wdata_in[8], wdata_in[6], wdata_in[4], wdata_in[2], wdata_in[0]}))
        else $error("source single lanes wrong");

    dst_lanes_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && enable_ff && addr_in == dma_regs_pkg::OFS_CHK_REQ
        |=> dst_chunk_req_out == $past({wdata_in[15], wdata_in[13], wdata_in[11],
            wdata_in[9], wdata_in[7], wdata_in[5], wdata_in[3], wdata_in[1]}))
        else $error("destination chunk lanes wrong");

    // Requests are pulses; a level here would repeat a transfer every cycle.
    dst_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (|dst_single_req_out) && !(wr_in && addr_in == dma_regs_pkg::OFS_SGL_REQ)
        |=> dst_single_req_out == 8'h00)
        else $error("destination single request held");

    chunk_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (|src_chunk_req_out) && !(wr_in && addr_in == dma_regs_pkg::OFS_CHK_REQ)
        |=> src_chunk_req_out == 8'h00)
        else $error("source chunk request held");

    mask_keep_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_MASK_SET |=> (mask_ff & ~$past(wdata_in[23:0]))
        == ($past(mask_ff) & ~$past(wdata_in[23:0])))
        else $error("mask set touched a zero bit");

    mask_keep_clr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_MASK_CLR |=> (mask_ff | $past(wdata_in[23:0]))
        == ($past(mask_ff) | $past(wdata_in[23:0])))
        else $error("mask clear touched a zero bit");

    mask_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !(wr_in && (addr_in == dma_regs_pkg::OFS_MASK_SET
            || addr_in == dma_regs_pkg::OFS_MASK_CLR))
        |=> $stable(mask_ff))
        else $error("mask changed without a write");

    buf_view_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == dma_regs_pkg::OFS_MASK_VIEW
        |=> rdata_out[dma_regs_pkg::BUF_LSB +: 8] == $past(mask_ff[dma_regs_pkg::BUF_LSB +: 8]))
        else $error("buffer mask view wrong");

    chain_view_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == dma_regs_pkg::OFS_MASK_VIEW
        |=> rdata_out[dma_regs_pkg::CHAIN_LSB +: 8]
            == $past(mask_ff[dma_regs_pkg::CHAIN_LSB +: 8]))
        else $error("chain mask view wrong");

    err_view_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == dma_regs_pkg::OFS_MASK_VIEW
        |=> rdata_out[dma_regs_pkg::ERR_LSB +: 8] == $past(mask_ff[dma_regs_pkg::ERR_LSB +: 8]))
        else $error("error mask view wrong");

    rdata_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !rd_in |=> rdata_out == 32'h0000_0000)
        else $error("read data outside the read slot");

    chain_sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        chain_done_in[0] |=> status_ff[8] && descriptor_fetch_stop_out[0])
        else $error("chain event lost");

    error_sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        bus_error_in[1] |=> status_ff[17])
        else $error("error event lost");

    err_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == dma_regs_pkg::OFS_STATUS
        |=> rdata_out[dma_regs_pkg::ERR_LSB +: 8] == $past(status_ff[dma_regs_pkg::ERR_LSB +: 8]))
        else $error("error flags read wrong");

    // A flag must stay until software clears it, or an interrupt could vanish unseen.
    status_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        status_ff[0] && !(wr_in && addr_in == dma_regs_pkg::OFS_STATUS && wdata_in[0])
        |=> status_ff[0])
        else $error("buffer flag dropped");

    status_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == dma_regs_pkg::OFS_STATUS && wdata_in[0] && !buffer_done_in[0]
        |=> !status_ff[0])
        else $error("buffer flag not cleared");

    irq_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        buffer_done_in[0] && mask_ff[0] && !(wr_in && addr_in == dma_regs_pkg::OFS_MASK_CLR)
        |=> irq_out)
        else $error("unmasked event raised no interrupt");

    irq_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        status_ff == 24'h00_0000 |-> !irq_out)
        else $error("interrupt without a flag");

endmodule // dma_sw_request_irq_regs

// *** tb_top.sv ***
/*
 * Self-checking bench for the DMA request and interrupt register group.
 * Assumes the register port answers a read one cycle later and never stalls.
 */
`timescale 1ns/1ns
module tb_top;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [7:0]  bdone, cdone, berr, ss, ds, sc, dc, sf, df, stop;
    logic        ctrl_enable_out, irq_out;
    int          err_count = 0;
    int          checks = 0;
    logic [11:0] ofs [6] = '{dma_regs_pkg::OFS_ENABLE, dma_regs_pkg::OFS_SGL_REQ,
        dma_regs_pkg::OFS_CHK_REQ, dma_regs_pkg::OFS_FINAL, dma_regs_pkg::OFS_MASK_VIEW,
        dma_regs_pkg::OFS_STATUS};
    logic [11:0] req_adr [4] = '{dma_regs_pkg::OFS_SGL_REQ, dma_regs_pkg::OFS_CHK_REQ,
        dma_regs_pkg::OFS_SGL_REQ, dma_regs_pkg::OFS_CHK_REQ};
    logic [31:0] req_dat [4] = '{32'h0000_5555, 32'h0000_AAAA, 32'h0000_AAAA, 32'h0000_5555};
    logic [47:0] req_exp [4] = '{48'hFF00_0000_0100, 48'h0000_00FF_0001, 48'h00FF_0000_0000,
        48'h0000_FF00_0000};

    dma_sw_request_irq_regs u_dma_sw_request_irq_regs (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .buffer_done_in(bdone), .chain_done_in(cdone),
        .bus_error_in(berr), .ctrl_enable_out(ctrl_enable_out), .src_single_req_out(ss),
        .dst_single_req_out(ds), .src_chunk_req_out(sc), .dst_chunk_req_out(dc),
        .src_final_out(sf), .dst_final_out(df), .descriptor_fetch_stop_out(stop),
        .irq_out(irq_out));
    chan_engine_model u_chan_engine_model (.clk_in(clk_in), .buffer_done_out(bdone),
        .chain_done_out(cdone), .bus_error_out(berr));

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check(48'(rdata_out), 48'(exp));
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // The whole run is about a hundred cycles, so this limit only cuts a hang.
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
        check(48'({ctrl_enable_out, irq_out}), 48'h0000_0000_0000);
        wr(dma_regs_pkg::OFS_SGL_REQ, 32'h0000_FFFF);
        check(48'({ss, ds, sc, dc}), 48'h0000_0000_0000);
        wr(dma_regs_pkg::OFS_ENABLE, 32'h0000_0001);
        check(48'(ctrl_enable_out), 48'h0000_0000_0001);
        rd(dma_regs_pkg::OFS_ENABLE, 32'h0000_0001);
        wr(dma_regs_pkg::OFS_FINAL, 32'h0000_0003);
        // Markers are consumed by the first request on their bit, so rows 2 and 3 see none.
        for (int i = 0; i < 4; i++) begin
            wr(req_adr[i], req_dat[i]);
            check({ss, ds, sc, dc, sf, df}, req_exp[i]);
        end
        settle();
        check(48'({ss, ds, sc, dc}), 48'h0000_0000_0000);
        wr(dma_regs_pkg::OFS_MASK_SET, 32'h0012_3456);
        wr(dma_regs_pkg::OFS_MASK_SET, 32'h0000_0001);
        wr(dma_regs_pkg::OFS_MASK_CLR, 32'h0010_0400);
        wr(dma_regs_pkg::OFS_MASK_VIEW, 32'hFFFF_FFFF);
        rd(dma_regs_pkg::OFS_MASK_VIEW, 32'h0002_3057);
        rd(12'h014, 32'h0000_0000);
        u_chan_engine_model.fire(24'h00_0001);
        settle();
        check(48'(irq_out), 48'h0000_0000_0001);
        rd(dma_regs_pkg::OFS_STATUS, 32'h0000_0001);
        wr(dma_regs_pkg::OFS_STATUS, 32'h0000_0001);
        settle();
        check(48'(irq_out), 48'h0000_0000_0000);
        // A clear in the same cycle as a new event must lose, or the event is missed.
        fork
            u_chan_engine_model.fire(24'h00_0001);
            wr(dma_regs_pkg::OFS_STATUS, 32'h0000_0001);
        join
        rd(dma_regs_pkg::OFS_STATUS, 32'h0000_0001);
        wr(dma_regs_pkg::OFS_STATUS, 32'h0000_0001);
        u_chan_engine_model.fire(24'h00_0100);
        settle();
        check(48'({irq_out, stop}), 48'h0000_0000_0001);
        wr(dma_regs_pkg::OFS_MASK_SET, 32'h0000_0100);
        settle();
        check(48'(irq_out), 48'h0000_0000_0001);
        u_chan_engine_model.fire(24'h02_0000);
        rd(dma_regs_pkg::OFS_STATUS, 32'h0002_0100);
        wr(dma_regs_pkg::OFS_MASK_CLR, 32'h00FF_FFFF);
        settle();
        check(48'(irq_out), 48'h0000_0000_0000);
        rd(dma_regs_pkg::OFS_MASK_VIEW, 32'h0000_0000);
        wr(dma_regs_pkg::OFS_ENABLE, 32'h0000_0000);
        wr(dma_regs_pkg::OFS_CHK_REQ, 32'h0000_FFFF);
        check(48'({ctrl_enable_out, ss, ds, sc, dc}), 48'h0000_0000_0000);
        rstn_in <= 1'b0;
        settle();
        check(48'({ctrl_enable_out, irq_out, stop}), 48'h0000_0000_0000);
        rstn_in <= 1'b1;
        rd(dma_regs_pkg::OFS_STATUS, 32'h0000_0000);
        stop_test();
    end
endmodule // tb_top
